// File: src/sfc_defs.svh
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH
// What this block does
// [R1] Watermark hit never stops sample intake
// [R2] Push one sample per acquisition period
// [R3] Data read returns oldest byte, pops queue
// [R4] Host drains FIFO by one burst read
// [R5] Policy codes: 00 off, 01 circular, 10 stop
// [R6] Circular full: drop oldest, keep newest
// [R7] Stop-on-full refuses samples while full
// [R8] Flush on disable or standby-to-active
// [R9] Writing disabled clears flags and count
// [R10] Overrun flag set when count reaches 32
// [R11] Watermark flag when count equals watermark
// [R12] Watermark zero suppresses watermark flag
// [R13] Host disables before changing policy
// [R14] Watermark writable in active state
// [R15] Policy writable only in standby
// [R16] Stall ticks count after overflow, clear on drain
// [R17] Run-state bit0 active, bits 7:1 zero
// [R18] 32 samples of five bytes, P then T
// [R19] Count reads 0 empty, 1..32 stored
// [R20] Circular overflow keeps count at 32
// [R21] Stall ticks saturate at 255

// Register offsets
`define SFC_ADDR_DATA   8'h0E
`define SFC_ADDR_SETUP  8'h0F
`define SFC_ADDR_STALL  8'h10
`define SFC_ADDR_RUN    8'h11
// Field layout of the setup register
`define SFC_POL_MSB     7
`define SFC_POL_LSB     6
`define SFC_WM_MSB      5
`define SFC_SETUP_RST   8'h00
// Policy codes
`define SFC_POL_OFF     2'h0
`define SFC_POL_CIRC    2'h1
`define SFC_POL_STOP    2'h2
// Geometry
`define SFC_DEPTH       32
`define SFC_FULL        6'h20
`define SFC_SAMPLE_W    40
`define SFC_LAST_BYTE   3'h4
`define SFC_TICK_MAX    8'hFF
`define SFC_BUF_FULL    2'h2
`endif

// File: src/sfc_pkg.sv
`include "sfc_defs.svh"
package sfc_pkg;
  // Register access strobe group from the serial front end
  typedef struct packed {
    logic [7:0] addr;   // Register offset
    logic       wr;     // One-cycle write strobe
    logic       rd;     // One-cycle read strobe
    logic [7:0] wdata;  // Write data
  } sfc_reg_req_type;

  // Whole state of the controller
  typedef struct packed {
    logic [`SFC_DEPTH-1:0][`SFC_SAMPLE_W-1:0] mem;       // Sample storage
    logic [4:0]                              wr_ptr;    // Next write slot
    logic [4:0]                              rd_ptr;    // Oldest sample
    logic [5:0]                              count;     // Stored samples
    logic [2:0]                              byte_idx;  // Byte within head sample
    logic [1:0]                              policy;    // Overflow policy
    logic [5:0]                              wmark;     // Watermark
    logic                                    ovf;       // Overrun flag
    logic                                    wm_flag;   // Watermark hit
    logic [7:0]                              stall;     // Stall ticks
    logic                                    stall_on;  // Stall counting armed
    logic                                    run;       // Active state copy
    logic [15:0]                             div;       // Period divider
    logic [2:0]                              clk_sync;  // Link clock sampler
    logic [1:0][`SFC_SAMPLE_W-1:0]           dat_sync;  // Sample word sampler
    logic                                    pend;      // Captured sample waiting
    logic [`SFC_SAMPLE_W-1:0]                pend_data; // Captured sample
    logic [1:0][`SFC_SAMPLE_W-1:0]           bdat;      // Two-entry buffer
    logic [1:0]                              bcnt;      // Buffer fill
    logic [7:0]                              rdata;     // Read answer
    logic                                    rvalid;    // Read answer strobe
  } sfc_state_type;
endpackage

// File: src/sfc_top.sv
`include "sfc_defs.svh"
module sfc_top (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_sample_clk,
  input  wire logic [39:0]             i_sample_data,
  input  wire logic [3:0]              i_acquisition_rate_select,
  input  wire logic                    i_active_mode,
  input  wire sfc_pkg::sfc_reg_req_type i_reg_req,
  output logic [7:0]                   o_reg_rdata,
  output logic                         o_reg_rvalid,
  output logic                         o_overrun_flag,
  output logic                         o_watermark_hit_flag,
  output logic [5:0]                   o_stored_sample_count,
  output logic                         o_system_run_state
);
  import sfc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Acquisition period in link clock edges, a power of two
  function automatic logic [15:0] period_edges(input logic [3:0] sel);
    period_edges = 16'h0001 << sel;
  endfunction

  // Pick one byte of a sample: pressure high first, temperature low last
  function automatic logic [7:0] sample_byte(input logic [39:0] s, input logic [2:0] i);
    case (i)
      3'h0:    sample_byte = s[39:32];
      3'h1:    sample_byte = s[31:24];
      3'h2:    sample_byte = s[23:16];
      3'h3:    sample_byte = s[15:8];
      3'h4:    sample_byte = s[7:0];
      default: sample_byte = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset release synchroniser

  logic [1:0] rst_sync;  // Release chain
  logic       rst_n;     // Reset used by the design

  // Assert at once, release after two clean edges
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  sfc_state_type st;        // Current state
  sfc_state_type next_st;   // Next state
  logic          tick;      // One acquisition period elapsed
  logic          enabled;   // Intake allowed
  logic          take_in;   // Captured sample enters buffer
  logic          acc;       // Buffer head offered to storage
  logic          data_rd;   // Read of the data port
  logic          pop;       // Byte taken from the queue
  logic          flush;     // Queue emptied this cycle

  always_comb begin
    next_st = st;
    tick    = 1'b0;
    pop     = 1'b0;
    flush   = 1'b0;
    // Samplers: the first stage is read only by the second
    next_st.clk_sync = {st.clk_sync[1:0], i_sample_clk};
    next_st.dat_sync = {st.dat_sync[0], i_sample_data};
    next_st.run      = i_active_mode;
    next_st.rvalid   = 1'b0;

    // Divide rising link clock edges down to the acquisition rate
    if (st.clk_sync[1] && !st.clk_sync[2]) begin
      if (st.div >= period_edges(i_acquisition_rate_select) - 16'h0001) begin
        next_st.div = 16'h0000;
        tick        = 1'b1;  // see [R2]
      end else begin
        next_st.div = st.div + 16'h0001;
      end
    end

    // Stall ticks grow each period once armed and stop at the top
    if (tick && st.stall_on && st.stall != `SFC_TICK_MAX) begin
      next_st.stall = st.stall + 8'h01;  // see [R16] see [R21]
    end

    enabled = st.run && (st.policy == `SFC_POL_CIRC || st.policy == `SFC_POL_STOP);
    data_rd = i_reg_req.rd && i_reg_req.addr == `SFC_ADDR_DATA;
    // Captured sample waits until the buffer has room
    take_in = st.pend && st.bcnt != `SFC_BUF_FULL;
    // Storage is stalled while a data byte is being read
    acc     = st.bcnt != 2'h0 && !data_rd;

    // Buffer drain side
    if (acc) begin
      next_st.bdat[0] = st.bdat[1];
      next_st.bcnt    = st.bcnt - 2'h1;
    end
    // Buffer fill side
    if (take_in) begin
      next_st.bdat[next_st.bcnt[0]] = st.pend_data;
      next_st.bcnt = next_st.bcnt + 2'h1;
      next_st.pend = 1'b0;
    end
    // A new period captures a fresh sample
    if (tick && enabled) begin
      next_st.pend      = 1'b1;
      next_st.pend_data = st.dat_sync[1];
    end

    // Storage intake, never gated by the watermark
    if (acc && enabled) begin  // see [R1]
      if (st.count != `SFC_FULL) begin
        next_st.mem[st.wr_ptr] = st.bdat[0];
        next_st.wr_ptr = st.wr_ptr + 5'h01;
        next_st.count  = st.count + 6'h01;
        if (st.count == `SFC_FULL - 6'h01) begin
          next_st.ovf      = 1'b1;  // see [R10]
          next_st.stall_on = 1'b1;  // see [R16]
        end
      end else if (st.policy == `SFC_POL_CIRC) begin
        // Overwrite the oldest; the count stays at capacity
        next_st.mem[st.wr_ptr] = st.bdat[0];  // see [R6] see [R20]
        next_st.wr_ptr   = st.wr_ptr + 5'h01;
        next_st.rd_ptr   = st.rd_ptr + 5'h01;
        next_st.byte_idx = 3'h0;
        next_st.stall_on = 1'b1;
      end
      // Stop policy at capacity: the sample is refused, see [R7]
    end

    // Register reads
    if (data_rd && st.count != 6'h00) begin
      pop = 1'b1;
      next_st.rdata    = sample_byte(st.mem[st.rd_ptr], st.byte_idx);  // see [R3] see [R18]
      next_st.byte_idx = st.byte_idx + 3'h1;
      if (st.byte_idx == `SFC_LAST_BYTE) begin
        next_st.byte_idx = 3'h0;
        next_st.rd_ptr   = st.rd_ptr + 5'h01;
        next_st.count    = st.count - 6'h01;
        if (st.count == 6'h01) begin
          next_st.stall    = 8'h00;  // see [R16]
          next_st.stall_on = 1'b0;
        end
      end
    end else begin
      case (i_reg_req.addr)
        `SFC_ADDR_SETUP: next_st.rdata = {st.policy, st.wmark};
        `SFC_ADDR_STALL: next_st.rdata = st.stall;
        `SFC_ADDR_RUN:   next_st.rdata = {7'h00, st.run};  // see [R17]
        default:         next_st.rdata = 8'h00;
      endcase
    end
    if (i_reg_req.rd) begin
      next_st.rvalid = 1'b1;
    end

    // Setup writes: watermark any time, policy only in standby
    if (i_reg_req.wr && i_reg_req.addr == `SFC_ADDR_SETUP) begin
      next_st.wmark = i_reg_req.wdata[`SFC_WM_MSB:0];  // see [R14]
      // Direct swap between the two live policies is ignored
      if (!st.run && (st.policy == `SFC_POL_OFF ||
          i_reg_req.wdata[`SFC_POL_MSB:`SFC_POL_LSB] == `SFC_POL_OFF)) begin
        next_st.policy = i_reg_req.wdata[`SFC_POL_MSB:`SFC_POL_LSB];  // see [R15] see [R5] see [R13]
      end
    end

    // Flush while disabled and on entry to the active state
    flush = next_st.policy == `SFC_POL_OFF || (i_active_mode && !st.run);  // see [R8]
    if (flush) begin
      next_st.wr_ptr   = 5'h00;  // see [R9]
      next_st.rd_ptr   = 5'h00;
      next_st.count    = 6'h00;
      next_st.byte_idx = 3'h0;
      next_st.ovf      = 1'b0;
      next_st.stall    = 8'h00;
      next_st.stall_on = 1'b0;
      next_st.bcnt     = 2'h0;
      next_st.pend     = 1'b0;
    end

    // Watermark: raised on equality, held while the count stays at or above
    next_st.wm_flag = next_st.wmark != 6'h00 && next_st.count >= next_st.wmark &&
                      (st.wm_flag || next_st.count == next_st.wmark);  // see [R11] see [R12]
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  // Whole state clears at reset, storage included, at the cost of a wide reset
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register
  assign o_reg_rdata           = st.rdata;
  assign o_reg_rvalid          = st.rvalid;
  assign o_overrun_flag        = st.ovf;
  assign o_watermark_hit_flag  = st.wm_flag;
  assign o_stored_sample_count = st.count;
  assign o_system_run_state    = st.run;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  // Watermark flag never shows with a zero watermark
  property p_wm_zero;
    st.wmark == 6'h00 |-> !st.wm_flag;
  endproperty
  a_wm_zero: assert property (p_wm_zero) else $error("watermark flag with zero mark"); // see [R12]

  // Flag rises exactly when count first meets the mark
  property p_wm_rise;
    $rose(st.wm_flag) |-> st.count == st.wmark;
  endproperty
  a_wm_rise: assert property (p_wm_rise) else $error("watermark rose off the mark"); // see [R11]

  // Count never passes capacity
  property p_cap;
    st.count <= `SFC_FULL;
  endproperty
  a_cap: assert property (p_cap) else $error("count above capacity"); // see [R19]

  // Full count carries the overrun flag
  property p_ovf;
    st.count == `SFC_FULL |-> st.ovf;
  endproperty
  a_ovf: assert property (p_ovf) else $error("full without overrun"); // see [R10]

  // Fifth byte of a sample drops the count by one
  property p_pop;
    pop && st.byte_idx == `SFC_LAST_BYTE && !flush |=> st.count == $past(st.count) - 6'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not decrement"); // see [R3]

  // Circular overwrite keeps count full and moves the head
  property p_circ;
    acc && enabled && st.policy == `SFC_POL_CIRC && st.count == `SFC_FULL && !flush
      |=> st.count == `SFC_FULL && st.rd_ptr == $past(st.rd_ptr) + 5'h01;
  endproperty
  a_circ: assert property (p_circ) else $error("circular overwrite wrong"); // see [R20]

  // Stop policy leaves the write pointer where it was
  property p_stop;
    acc && st.policy == `SFC_POL_STOP && st.count == `SFC_FULL && !flush |=> $stable(st.wr_ptr);
  endproperty
  a_stop: assert property (p_stop) else $error("sample stored while full"); // see [R7]

  // Disabled policy leaves an empty queue with clear flags
  property p_off;
    st.policy == `SFC_POL_OFF |-> st.count == 6'h00 && !st.ovf && !st.wm_flag;
  endproperty
  a_off: assert property (p_off) else $error("disabled queue not clear"); // see [R9]

  // Stall ticks hold at the top until drained or flushed
  property p_sat;
    st.stall == `SFC_TICK_MAX && !pop && !flush |=> st.stall == `SFC_TICK_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("stall ticks wrapped"); // see [R21]

  // Run-state read answers with upper bits clear
  property p_run;
    i_reg_req.rd && i_reg_req.addr == `SFC_ADDR_RUN |=> o_reg_rvalid && o_reg_rdata[7:1] == 7'h00;
  endproperty
  a_run: assert property (p_run) else $error("run-state read wrong"); // see [R17]

  // Entering the active state empties the queue
  property p_flush_entry;
    i_active_mode && !st.run |=> st.count == 6'h00 && !st.ovf && st.stall == 8'h00;
  endproperty
  a_flush_entry: assert property (p_flush_entry) else $error("entry to active did not flush"); // see [R8]

  // A raised watermark flag never holds back storage
  property p_intake_wm;
    acc && enabled && st.wm_flag && st.count != `SFC_FULL && !flush |=> st.count == $past(st.count) + 6'h01;
  endproperty
  a_intake_wm: assert property (p_intake_wm) else $error("intake stopped at watermark"); // see [R1]

  // Each acquisition tick with intake enabled captures the synchronised sample
  property p_tick_cap;
    tick && enabled && !flush |=> st.pend && st.pend_data == $past(st.dat_sync[1]);
  endproperty
  a_tick_cap: assert property (p_tick_cap) else $error("tick did not capture"); // see [R2]

  // Last byte of the last sample clears the stall ticks
  property p_stall_clr;
    pop && st.byte_idx == `SFC_LAST_BYTE && st.count == 6'h01 |=> st.stall == 8'h00;
  endproperty
  a_stall_clr: assert property (p_stall_clr) else $error("stall ticks kept after drain"); // see [R16]

  // Stall ticks stay at zero until armed by overflow or wrap
  property p_stall_idle;
    !st.stall_on |-> st.stall == 8'h00;
  endproperty
  a_stall_idle: assert property (p_stall_idle) else $error("stall ticks before overflow"); // see [R16]

  // Policy is frozen while active
  property p_pol_hold;
    st.run |=> $stable(st.policy);
  endproperty
  a_pol_hold: assert property (p_pol_hold) else $error("policy changed while active"); // see [R15]

  // A live policy only ever gives way to the disabled code
  property p_pol_swap;
    st.policy == `SFC_POL_CIRC || st.policy == `SFC_POL_STOP
      |=> st.policy == $past(st.policy) || st.policy == `SFC_POL_OFF;
  endproperty
  a_pol_swap: assert property (p_pol_swap) else $error("direct policy swap taken"); // see [R13]

  // Data read of an empty queue answers zero and pops nothing
  property p_empty_read;
    data_rd && st.count == 6'h00 |=> o_reg_rdata == 8'h00 && st.count == 6'h00;
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty data read wrong"); // see [R19]

  // Flag stays low while the count is below the mark
  property p_wm_below;
    st.count < st.wmark |-> !st.wm_flag;
  endproperty
  a_wm_below: assert property (p_wm_below) else $error("watermark flag below the mark"); // see [R11]

  // Watermark takes every setup write, active or not
  property p_wmark_wr;
    i_reg_req.wr && i_reg_req.addr == `SFC_ADDR_SETUP |=> st.wmark == $past(i_reg_req.wdata[`SFC_WM_MSB:0]);
  endproperty
  a_wmark_wr: assert property (p_wmark_wr) else $error("watermark write lost"); // see [R14]

  // Overrun flag holds until the queue is flushed
  property p_ovf_hold;
    st.ovf && !flush |=> st.ovf;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overrun flag dropped"); // see [R10]
endmodule

// File: tb/sfc_sample_src.sv
// Far-side sample source: a gated link clock plus a 40-bit sample word
module sfc_sample_src (
  input  wire logic        i_enable,
  output logic             o_sample_clk,
  output logic [39:0]      o_sample_data
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////
  // Clock runs only while enabled and stands low between bursts.
  // Odd half periods keep its rises off the system clock edges; its falls land on them.
  initial begin
    o_sample_clk  = 1'b0;
    o_sample_data = 40'h0;
    forever begin
      wait (i_enable === 1'b1);
      #163 o_sample_clk = 1'b1; // One measurement per rise
      #157 o_sample_clk = 1'b0;
      // New word after the fall, so it is steady around the rise
      o_sample_data = {$urandom, 8'($urandom)};
    end
  end
endmodule

// File: tb/tb_sample_fifo_control.sv
module tb_sample_fifo_control;
  timeunit 1ns;
  timeprecision 1ps;
  import sfc_pkg::*;
  logic            sys_clk = 1'b0;     // System clock
  logic            reset_n = 1'b0;     // Reset, active low
  logic            act     = 1'b0;     // Active mode request
  logic            src_en  = 1'b0;     // Sample source gate
  logic [3:0]      rsel    = 4'h0;     // Acquisition rate select
  sfc_reg_req_type req     = '0;       // Register strobes
  wire logic       sclk;               // Link clock
  wire logic [39:0] sdat;              // Sample word
  logic [7:0]      rdata;              // Read answer
  logic            rvalid, ovf, wmh, run_st; // Status outputs
  logic [5:0]      cnt;                // Stored sample count
  int              err_count = 0;      // Mismatches
  int              checks = 0;         // Comparisons
  // Reference model state
  logic [39:0]     mq[$];              // Stored samples, oldest first
  logic [1:0]      m_pol = 2'h0;       // Policy
  logic [5:0]      m_wm = 6'h00;       // Watermark
  logic            m_run = 1'b0, m_ovf = 1'b0, m_arm = 1'b0;
  int              m_st = 0, m_b = 0;  // Stall ticks, byte position
  logic [7:0]      d;
  int              n;

  sfc_sample_src src (.i_enable(src_en), .o_sample_clk(sclk), .o_sample_data(sdat));
  sfc_top dut (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_sample_clk(sclk), .i_sample_data(sdat),
    .i_acquisition_rate_select(rsel), .i_active_mode(act), .i_reg_req(req), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .o_overrun_flag(ovf), .o_watermark_hit_flag(wmh),
    .o_stored_sample_count(cnt), .o_system_run_state(run_st));

  ////////////////////////////////////////////////////////////////
  // Clock and watchdog (whole run is well under 1 ms)
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #2000000;
    err_count++;
    $display("Error %0t: watchdog expired", $time);
    test_done();
  end

  ////////////////////////////////////////////////////////////////
  // Model: one tick per link rise at rate 0 only
  always @(posedge sclk) begin
    if (rsel == 4'h0 && m_run && (m_pol == 2'h1 || m_pol == 2'h2)) begin
      if (m_arm) m_st = (m_st < 255) ? m_st + 1 : 255; // Saturate
      if (mq.size() < 32) begin
        mq.push_back(sdat);
      end else if (m_pol == 2'h1) begin
        void'(mq.pop_front()); // Drop oldest
        mq.push_back(sdat);
        m_b = 0;
      end
      if (mq.size() == 32) begin
        m_ovf = 1'b1;
        m_arm = 1'b1;
      end
    end
  end

  function automatic void m_flush();
    mq.delete();
    m_ovf = 1'b0;
    m_arm = 1'b0;
    m_st  = 0;
    m_b   = 0;
  endfunction

  ////////////////////////////////////////////////////////////////
  // Compares and closing
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_status();
    logic [7:0] e;
    e = {m_ovf, (m_wm != 6'h00) && (mq.size() >= m_wm), 6'(mq.size())};
    checks++;
    if ({ovf, wmh, cnt} !== e) begin
      err_count++;
      $display("Error %0t: status got %h expected %h", $time, {ovf, wmh, cnt}, e);
    end
  endtask
  task automatic test_done();
    $display("Counts: %0d mismatches in %0d checks", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Register strobes, changed at the falling edge only
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    @(negedge sys_clk);
    req.wr = 1'b0;
    if (a == 8'h0F) begin
      m_wm = v[5:0];
      // Policy changes only in standby, and only via disabled
      if (!m_run && (m_pol == 2'h0 || v[7:6] == 2'h0)) begin
        m_pol = v[7:6];
        if (v[7:6] == 2'h0) m_flush();
      end
    end
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge sys_clk);
    req.rd = 1'b0;
    // Answer strobe must stand exactly one cycle after the request
    cmp_byte({7'h00, rvalid}, 8'h01);
    v = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_rd(a, d);
    cmp_byte(d, exp);
  endtask
  // Burst of data-port reads, byte by byte against the model
  task automatic drain(input int samples);
    repeat (samples * 5) begin
      rd_chk(8'h0E, (mq.size() != 0) ? mq[0][39 - 8 * m_b -: 8] : 8'h00);
      if (mq.size() != 0) begin
        m_b++;
        if (m_b == 5) begin
          void'(mq.pop_front());
          m_b = 0;
          if (mq.size() == 0) begin
            m_st  = 0;
            m_arm = 1'b0;
          end
        end
      end
    end
  endtask
  task automatic set_act(input logic v);
    @(negedge sys_clk);
    act = v;
    if (v && !m_run) m_flush();
    m_run = v;
    repeat (3) @(negedge sys_clk);
  endtask
  // Let n link rises through, then allow the pipeline to settle
  task automatic ticks(input int cnt_n);
    src_en = 1'b1;
    repeat (cnt_n) @(posedge sclk);
    src_en = 1'b0;
    repeat (12) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'hA578));
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd_chk(8'h0F, 8'h00);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h11, 8'h00);
    rd_chk(8'h20, 8'h00);
    set_act(1'b1);
    ticks(4);
    cmp_status();
    rd_chk(8'h11, 8'h01);
    cmp_byte({7'h0, run_st}, 8'h01);
    reg_wr(8'h0F, 8'h85);
    rd_chk(8'h0F, 8'h05);
    set_act(1'b0);
    reg_wr(8'h0F, 8'h45);
    set_act(1'b1);
    n = $urandom_range(6, 9);
    ticks(n);
    cmp_status();
    drain(3);
    cmp_status();
    reg_wr(8'h0F, 8'h40);
    ticks(2);
    cmp_status();
    ticks(300);
    cmp_status();
    rd_chk(8'h10, 8'hFF);
    drain(32);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h0E, 8'h00);
    ticks(35);
    rd_chk(8'h10, 8'h03);
    set_act(1'b0);
    reg_wr(8'h0F, 8'h80);
    rd_chk(8'h0F, 8'h40);
    reg_wr(8'h0F, 8'h00);
    cmp_status();
    // Unused policy code is stored but takes no samples
    reg_wr(8'h0F, 8'hC0);
    rd_chk(8'h0F, 8'hC0);
    set_act(1'b1);
    ticks(2);
    cmp_status();
    set_act(1'b0);
    reg_wr(8'h0F, 8'h00);
    reg_wr(8'h0F, 8'h8A);
    set_act(1'b1);
    ticks(40);
    cmp_status();
    drain(32);
    ticks(4);
    set_act(1'b0);
    set_act(1'b1);
    cmp_status();
    @(negedge sys_clk);
    rsel = 4'h2;
    ticks(8);
    cmp_byte({2'h0, cnt}, 8'h02);
    test_done();
  end
endmodule
